// file: src/dca_serial_port.sv
`timescale 1ns/1ps
`default_nettype none
module dca_serial_port (
   // Core clock and reset
   input  wire logic                 ref_clk_i,
   input  wire logic                 reset_n_i,
   // Serial link
   input  wire logic                 frame_sel_n_i,
   input  wire logic                 link_sclk_i,
   input  wire logic                 link_din_i,
   output logic                      link_dout_o,
   output logic                      link_dout_oe_o,
   // Converter core side
   input  wire dca_pkg::dca_codes_s  codes_i,
   output dca_pkg::dca_status_s      status_o
);

   // Internal shift clock, held high outside a frame
   wire logic int_clk;
   assign int_clk = link_sclk_i | frame_sel_n_i;

   dca_pkg::dca_rise_s rise_ff;
   dca_pkg::dca_rise_s nxt_rise;
   dca_pkg::dca_fall_s fall_ff;
   dca_pkg::dca_fall_s nxt_fall;
   logic [1:0]         chan_ff;
   logic [1:0]         nxt_chan;
   dca_pkg::dca_core_s core_ff;
   dca_pkg::dca_core_s nxt_core;

   logic [dca_pkg::SYNC_W-1:0] sync_q;
   logic                       frame_n_s;
   logic                       hold_s;
   logic                       active_s;
   logic [1:0]                 chan_s;
   dca_pkg::dca_chan_e         chan_dec;

   // ---------------- Link domain, rising edges ----------------
   always_comb begin
      nxt_rise     = rise_ff;
      nxt_rise.cnt = rise_ff.cnt + 4'h1;
      if (rise_ff.cnt < dca_pkg::CNT_CTRL_END) begin
         nxt_rise.ctrl = {rise_ff.ctrl[dca_pkg::CTRL_W-2:0],
                          link_din_i};
      end
   end

   // Frame select high clears the frame state
   always_ff @(posedge int_clk or posedge frame_sel_n_i) begin
      if (frame_sel_n_i) begin
         rise_ff <= dca_pkg::RISE_RST;
      end else begin
         rise_ff <= nxt_rise;
      end
   end

   // Selection persists across frames, takes effect next conversion
   always_comb begin
      nxt_chan = chan_ff;
      if (rise_ff.cnt == dca_pkg::CNT_LAST) begin
         nxt_chan = rise_ff.ctrl[dca_pkg::CHAN_MSB:dca_pkg::CHAN_LSB];
      end
   end

   always_ff @(posedge int_clk or posedge core_ff.link_rst) begin
      if (core_ff.link_rst) begin
         chan_ff <= dca_pkg::CHAN_RST;
      end else begin
         chan_ff <= nxt_chan;
      end
   end

   // ---------------- Link domain, falling edges ----------------
   always_comb begin
      nxt_fall        = fall_ff;
      nxt_fall.active = (rise_ff.cnt != dca_pkg::CNT_LAST);
      nxt_fall.hold   = (rise_ff.cnt >= dca_pkg::CNT_TRACK_END);
      nxt_fall.dout   = 1'b0;
      if (rise_ff.cnt >= dca_pkg::CNT_MSB) begin
         nxt_fall.dout = core_ff.result[4'(dca_pkg::CNT_LAST - rise_ff.cnt)];
      end
   end

   always_ff @(negedge int_clk or posedge frame_sel_n_i) begin
      if (frame_sel_n_i) begin
         fall_ff <= dca_pkg::FALL_RST;
      end else begin
         fall_ff <= nxt_fall;
      end
   end

   assign link_dout_o = fall_ff.dout;

   // ---------------- Crossing into the core domain ----------------
   dca_sync2 #(
      .W       (dca_pkg::SYNC_W),
      .RST_VAL (dca_pkg::SYNC_RST)
   ) u_sync (
      .clk_i     (ref_clk_i),
      .reset_n_i (reset_n_i),
      .d_i       ({frame_sel_n_i, fall_ff.hold, fall_ff.active, chan_ff}),
      .q_o       (sync_q)
   );

   assign {frame_n_s, hold_s, active_s, chan_s} = sync_q;
   assign chan_dec = dca_pkg::sel_decode(chan_s);

   // ---------------- Core domain ----------------
   always_comb begin
      nxt_core          = core_ff;
      nxt_core.dout_oe  = ~frame_n_s;
      nxt_core.link_rst = 1'b0;
      nxt_core.hold_d   = hold_s;
      // Freeze the selected input at the start of hold
      if (hold_s && !core_ff.hold_d) begin
         case (chan_dec)
            dca_pkg::DCA_CH_A: begin
               nxt_core.result = codes_i.a;
            end
            dca_pkg::DCA_CH_B: begin
               nxt_core.result = codes_i.b;
            end
            default: begin
               nxt_core.result = 12'h000;
            end
         endcase
      end
      nxt_core.status.power_down = frame_n_s | ~active_s;
      nxt_core.status.track      = ~frame_n_s & active_s & ~hold_s;
      nxt_core.status.sel_b      = (chan_dec == dca_pkg::DCA_CH_B);
      nxt_core.status.bad_sel    = (chan_dec == dca_pkg::DCA_CH_BAD);
      if (!reset_n_i) begin
         nxt_core = dca_pkg::CORE_RST;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      core_ff <= nxt_core;
   end

   assign link_dout_oe_o = core_ff.dout_oe;
   assign status_o       = core_ff.status;

   // ---------------- Checks ----------------
   sequence s_conv_wrap;
      (rise_ff.cnt == dca_pkg::CNT_LAST) ##1 (rise_ff.cnt == 4'h0);
   endsequence

   property p_oe_frame;
      @(posedge ref_clk_i) disable iff (!reset_n_i)
      !frame_n_s |=> link_dout_oe_o ##0 (!frame_n_s [*1] or frame_n_s);
   endproperty
   a_oe_frame: assert property (p_oe_frame)
      else $error("result pin not enabled during frame");

   property p_track_first;
      @(negedge int_clk) disable iff (frame_sel_n_i)
      (rise_ff.cnt inside {4'h1, 4'h2, 4'h3}) |-> !fall_ff.hold;
   endproperty
   a_track_first: assert property (p_track_first)
      else $error("hold entered before fourth falling edge");

   property p_hold_fourth;
      @(negedge int_clk) disable iff (frame_sel_n_i)
      (rise_ff.cnt == dca_pkg::CNT_MSB) |-> fall_ff.hold;
   endproperty
   a_hold_fourth: assert property (p_hold_fourth)
      else $error("hold missing after fourth falling edge");

   property p_retrack;
      @(negedge int_clk) disable iff (frame_sel_n_i)
      s_conv_wrap |=> !fall_ff.hold;
   endproperty
   a_retrack: assert property (p_retrack)
      else $error("no return to track after sixteenth rise");

   property p_msb_out;
      @(negedge int_clk) disable iff (frame_sel_n_i)
      (rise_ff.cnt == dca_pkg::CNT_MSB)
         |=> (link_dout_o == core_ff.result[dca_pkg::RESULT_W-1]);
   endproperty
   a_msb_out: assert property (p_msb_out)
      else $error("result MSB not on fifth clock");

   property p_lead_zero;
      @(negedge int_clk) disable iff (frame_sel_n_i)
      (rise_ff.cnt < dca_pkg::CNT_MSB) |=> !link_dout_o;
   endproperty
   a_lead_zero: assert property (p_lead_zero)
      else $error("nonzero bit ahead of result MSB");

   property p_ctrl_frozen;
      @(posedge int_clk) disable iff (frame_sel_n_i)
      (rise_ff.cnt > dca_pkg::CNT_CTRL_END) |-> $stable(rise_ff.ctrl);
   endproperty
   a_ctrl_frozen: assert property (p_ctrl_frozen)
      else $error("control word shifted after eighth rise");

   property p_chan_at_end;
      @(posedge int_clk) disable iff (core_ff.link_rst || frame_sel_n_i)
      $changed(chan_ff) |-> ($past(rise_ff.cnt) == dca_pkg::CNT_LAST);
   endproperty
   a_chan_at_end: assert property (p_chan_at_end)
      else $error("selection changed inside a conversion");

   property p_pd_gap;
      @(negedge int_clk) disable iff (frame_sel_n_i)
      (rise_ff.cnt == dca_pkg::CNT_LAST) |=> !fall_ff.active;
   endproperty
   a_pd_gap: assert property (p_pd_gap)
      else $error("no power-down between conversions");

   property p_pick_a;
      @(posedge ref_clk_i) disable iff (!reset_n_i)
      ($rose(hold_s) && chan_s == 2'h0) |=> (core_ff.result == $past(codes_i.a));
   endproperty
   a_pick_a: assert property (p_pick_a)
      else $error("input A not captured");

endmodule
`default_nettype wire

// file: inc/dca_pkg.sv
// Overview of operation
// - A frame runs from frame select falling to frame select rising.
// - Result pin is released while frame select is high, driven while low.
// - First three shift cycles of each conversion are track cycles.
// - Hold for thirteen cycles; 12-bit result MSB first from fifth clock.
// - Back-to-back: track after each 16th rise, hold at 4th fall.
// - Shift clock gated off outside frames; frame start counts as a fall.
// - With shift clock resting high, tracking starts on its first fall.
// - Control input captured on first eight rising edges, MSB first.
// - Control word selects the input for the following conversion.
// - Edges too close may delay control capture by one clock.
// - No warm-up; first conversion after power-up samples input A.
// - Channel selection lives in control bits 4 and 3; others ignored.
// - Code 00 picks input A, 01 picks input B.
// - Result is unsigned straight binary over 4096 codes.
// - Powered down while frame select high and between conversions.
// - Result changes after falling edges; control sampled on rising edges.
package dca_pkg;

   localparam int RESULT_W = 12;
   localparam int CTRL_W   = 8;
   localparam int SYNC_W   = 5;

   // Counts of rising edges already seen in the current conversion
   localparam logic [3:0] CNT_TRACK_END = 4'h3;
   localparam logic [3:0] CNT_MSB       = 4'h4;
   localparam logic [3:0] CNT_CTRL_END  = 4'h8;
   localparam logic [3:0] CNT_LAST      = 4'hF;

   // Channel field position inside the control word
   localparam int CHAN_LSB = 3;
   localparam int CHAN_MSB = 4;

   typedef enum logic [1:0] {
      DCA_CH_A,
      DCA_CH_B,
      DCA_CH_BAD
   } dca_chan_e;

   typedef struct packed {
      logic [RESULT_W-1:0] a;
      logic [RESULT_W-1:0] b;
   } dca_codes_s;

   typedef struct packed {
      logic power_down;
      logic track;
      logic sel_b;
      logic bad_sel;
   } dca_status_s;

   typedef struct packed {
      logic [3:0]        cnt;
      logic [CTRL_W-1:0] ctrl;
   } dca_rise_s;

   typedef struct packed {
      logic hold;
      logic active;
      logic dout;
   } dca_fall_s;

   typedef struct packed {
      logic                dout_oe;
      logic                link_rst;
      logic                hold_d;
      logic [RESULT_W-1:0] result;
      dca_status_s         status;
   } dca_core_s;

   localparam dca_rise_s   RISE_RST   = '{cnt: 4'h0, ctrl: 8'h00};
   localparam dca_fall_s   FALL_RST   = '{hold: 1'b0, active: 1'b0,
                                          dout: 1'b0};
   localparam dca_status_s STATUS_RST = '{power_down: 1'b1, track: 1'b0,
                                          sel_b: 1'b0, bad_sel: 1'b0};
   localparam dca_core_s   CORE_RST   = '{dout_oe: 1'b0, link_rst: 1'b1,
                                          hold_d: 1'b0, result: 12'h000,
                                          status: STATUS_RST};
   localparam logic [1:0]  CHAN_RST   = 2'h0;
   // Frame select rests high, everything else low
   localparam logic [SYNC_W-1:0] SYNC_RST = 5'h10;

   function automatic dca_chan_e sel_decode(input logic [1:0] chan);
      if (chan[1]) begin
         return DCA_CH_BAD;
      end else if (chan[0]) begin
         return DCA_CH_B;
      end else begin
         return DCA_CH_A;
      end
   endfunction

endpackage

// file: src/dca_sync2.sv
`timescale 1ns/1ps
`default_nettype none
module dca_sync2 #(
   parameter int             W       = 1,
   parameter logic [W-1:0]   RST_VAL = '0
) (
   // Clock and reset
   input  wire logic         clk_i,
   input  wire logic         reset_n_i,
   // Data
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);

   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] q;
   } dca_sync_s;

   dca_sync_s sync_ff;
   dca_sync_s nxt_sync;

   always_comb begin
      nxt_sync.meta = d_i;
      nxt_sync.q    = sync_ff.meta;
      if (!reset_n_i) begin
         nxt_sync.meta = RST_VAL;
         nxt_sync.q    = RST_VAL;
      end
   end

   always_ff @(posedge clk_i) begin
      sync_ff <= nxt_sync;
   end

   assign q_o = sync_ff.q;

endmodule
`default_nettype wire

// file: bench/dca_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module dca_host_model (
   // Link towards the device
   output logic                  frame_sel_n_o,
   output logic                  link_sclk_o,
   output logic                  link_din_o,
   input  wire logic             link_dout_i,
   input  wire logic             link_dout_oe_i,
   // Core-side view, sampled with the result bits
   input  wire dca_pkg::dca_status_s status_i
);
   localparam realtime HALF = 62.5;

   initial begin
      frame_sel_n_o = 1'b1;
      link_sclk_o   = 1'b0;
      link_din_o    = 1'b0;
   end

   // Shift clock parked at rest_hi, then select falls
   task automatic open_frame(input logic rest_hi);
      link_sclk_o = rest_hi;
      #(HALF);
      frame_sel_n_o = 1'b0;
      #(HALF);
   endtask

   // One conversion of sixteen rises, control word MSB first
   task automatic convert(input logic [7:0] ctrl, output logic [15:0] rx,
                          output logic [15:0] trk, output logic [15:0] pd,
                          output logic [15:0] oe);
      for (int k = 0; k < 16; k++) begin
         if (link_sclk_o) begin
            link_sclk_o = 1'b0;
         end
         // Unused bit periods toggle to show they are ignored
         link_din_o = (k < 8) ? ctrl[7-k] : ~link_din_o;
         #(HALF);
         link_sclk_o = 1'b1;
         rx[15-k]  = link_dout_i;
         trk[15-k] = status_i.track;
         pd[15-k]  = status_i.power_down;
         oe[15-k]  = link_dout_oe_i;
         #(HALF);
      end
   endtask

   // Select rises with the shift clock parked at rest_hi
   task automatic close_frame(input logic rest_hi);
      link_sclk_o = rest_hi;
      #(HALF);
      frame_sel_n_o = 1'b1;
      link_din_o    = ~link_din_o;
      #(HALF);
   endtask
endmodule
`default_nettype wire

// file: bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic                 ref_clk;
   logic                 reset_n;
   logic                 frame_sel_n;
   logic                 link_sclk;
   logic                 link_din;
   logic                 link_dout;
   logic                 link_dout_oe;
   dca_pkg::dca_codes_s  codes;
   dca_pkg::dca_status_s status;
   logic [15:0]          rx, trk, pd, oe;
   int                   err_total = 0;
   int                   cmp_count = 0;

   initial begin
      ref_clk = 1'b0;
      reset_n = 1'b0;
      codes   = '{a: 12'hA5C, b: 12'h3E1};
   end

   always #2 ref_clk = ~ref_clk;

   dca_serial_port DUT (
      .ref_clk_i      (ref_clk),
      .reset_n_i      (reset_n),
      .frame_sel_n_i  (frame_sel_n),
      .link_sclk_i    (link_sclk),
      .link_din_i     (link_din),
      .link_dout_o    (link_dout),
      .link_dout_oe_o (link_dout_oe),
      .codes_i        (codes),
      .status_o       (status)
   );

   dca_host_model u_host (
      .frame_sel_n_o  (frame_sel_n),
      .link_sclk_o    (link_sclk),
      .link_din_o     (link_din),
      .link_dout_i    (link_dout),
      .link_dout_oe_i (link_dout_oe),
      .status_i       (status)
   );

   task automatic chk_val(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic complete_run();
      $display("Compares %0d, mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // One conversion with result, phase and enable checks
   task automatic conv_chk(input logic [7:0] ctrl, input logic [11:0] code);
      u_host.convert(ctrl, rx, trk, pd, oe);
      chk_val(rx, {4'h0, code});
      chk_val(trk, 16'hE000);
      chk_val(pd, 16'h0001);
      chk_val(oe, 16'hFFFF);
   endtask

   // Idle checks between frames, with the pending selection
   task automatic idle_chk(input logic exp_b);
      chk_val({15'h0000, link_dout_oe}, 16'h0000);
      chk_val({15'h0000, status.power_down}, 16'h0001);
      chk_val({15'h0000, status.sel_b}, {15'h0000, exp_b});
      chk_val({15'h0000, status.bad_sel}, 16'h0000);
   endtask

   initial begin
      repeat (16) @(posedge ref_clk);
      reset_n <= 1'b1;
      repeat (8) @(posedge ref_clk);
      idle_chk(1'b0);
      // Clock resting low: select fall is the first falling edge
      u_host.open_frame(1'b0);
      conv_chk(8'hEF, 12'hA5C);
      conv_chk(8'hC7, 12'h3E1);
      conv_chk(8'h08, 12'hA5C);
      u_host.close_frame(1'b0);
      idle_chk(1'b1);
      @(posedge ref_clk);
      codes <= '{a: 12'h001, b: 12'hFFE};
      // Clock resting high: tracking starts on its first fall
      u_host.open_frame(1'b1);
      conv_chk(8'h00, 12'hFFE);
      conv_chk(8'h08, 12'h001);
      u_host.close_frame(1'b1);
      idle_chk(1'b1);
      complete_run();
   end

   // Whole sequence needs about 11 us
   initial begin
      #50000;
      err_total++;
      $display("BAD at %0t: sequence did not finish", $time);
      complete_run();
   end
endmodule
`default_nettype wire
